//--- pkg/lsc_pkg.sv
// Constants, register map and state codes for the load-shed priority controller.
// Assumes one 200 MHz clock and a one-second time base derived from it.
package lsc_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 5;
  localparam int SEC_NS = 1000000000;
  localparam int CYC_PER_SEC = SEC_NS / CLK_PERIOD_NS;
  localparam int TMR_W = 12;
  localparam logic [TMR_W-1:0] T_BASE_S = 12'd300;
  localparam logic [TMR_W-1:0] T_STEP_S = 12'd15;
  localparam logic [TMR_W-1:0] T_LOCK_S = 12'd1800;
  localparam logic [TMR_W-1:0] T_STABLE_S = 12'd60;
  localparam logic [TMR_W-1:0] T_PROBE_S = 12'd15;
  localparam logic [3:0] BLINK_SHED_S = 4'h1;
  localparam logic [3:0] BLINK_LOCK_S = 4'h3;
  localparam logic [3:0] BLINK_SWLK_S = 4'h6;
  localparam logic [3:0] DIAL_MIN = 4'h1;
  localparam logic [3:0] DIAL_MAX = 4'h8;
  // ----------------------------------------------------------------
  // Register map (byte addresses)
  // ----------------------------------------------------------------
  localparam int APB_AW = 8;
  localparam logic [APB_AW-1:0] ADDR_CTRL = 8'h00;
  localparam logic [APB_AW-1:0] ADDR_STATUS = 8'h04;
  localparam logic [APB_AW-1:0] ADDR_INT_STAT = 8'h08;
  localparam logic [APB_AW-1:0] ADDR_INT_CLR = 8'h0c;
  localparam logic [APB_AW-1:0] ADDR_INT_EN = 8'h10;
  localparam int CTRL_TEST_BIT = 0;
  localparam int NUM_EV = 4;
  localparam int EV_SHED = 0;
  localparam int EV_LOCK = 1;
  localparam int EV_SRC = 2;
  localparam int EV_CLOSE = 3;
  localparam int ST_STATE_LSB = 0;
  localparam int ST_CONT_BIT = 5;
  localparam int ST_LED_BIT = 6;
  localparam int ST_GEN_BIT = 7;
  localparam int ST_DIAL_LSB = 8;
  // ----------------------------------------------------------------
  // Controller states
  // ----------------------------------------------------------------
  typedef enum logic [4:0] {
    ST_NORM = 5'h01,
    ST_SHED = 5'h02,
    ST_PROBE = 5'h04,
    ST_LOCK = 5'h08,
    ST_SWLK = 5'h10
  } lsc_state_e;
endpackage : lsc_pkg

//--- rtl/lsc_sec_timer.sv
// Seconds countdown timer, advanced by a one-second tick.
// Assumes tick is a one-cycle pulse; load wins over the tick.
`timescale 1ns/100ps
module lsc_sec_timer #(
  parameter int W = 12
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic tick,
  input wire logic load,
  input wire logic [W-1:0] load_val,
  output logic done,
  output logic [W-1:0] remain
);
  logic [W-1:0] cnt_q;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
    end else if (load) begin
      cnt_q <= load_val;
    end else if (tick && cnt_q != '0) begin
      cnt_q <= cnt_q - 1'b1;
    end
  end

  assign done = (cnt_q == '0);
  assign remain = cnt_q;
endmodule : lsc_sec_timer

//--- rtl/lsc_ctrl.sv
// Load-shed priority controller: one contactor, one status LED, APB registers.
// Assumes all pin inputs are synchronous to pclk; overload and freq_low come
// from an external frequency monitor already qualified for duration.
//
// Overview of operation
// RL1: recovery delay five minutes plus fifteen seconds/step
// RL2: generator plus lockout switch keeps contactor open
// RL3: utility power ignores lockout switch, contactor closed
// RL4: generator, switch off: normal shed and recover
// RL5: overload opens contactor, LED blinks one second
// RL6: shed only on generator or startup window
// RL7: overload while recovering locks out thirty minutes
// RL8: generator lockout switch blinks LED six seconds
// RL9: utility with lockout switch shows steady LED
// RL10: normal state closes contactor, LED steady
// RL11: test forces shed except generator lockout
// RL12: contactor stays closed until generator takes over
// RL13: low frequency at reclose adds five minutes
// RL14: source change accepted after one stable minute
// RL15: utility return during lockout closes after five minutes
// RL16: dial 9 or 0 keeps generator output open
`timescale 1ns/100ps
module lsc_ctrl #(
  parameter int CYC_PER_SEC = lsc_pkg::CYC_PER_SEC
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [lsc_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [3:0] dial,
  input wire logic lock_sw,
  input wire logic test_btn,
  input wire logic util_src,
  input wire logic overload,
  input wire logic freq_low,
  output logic contactor,
  output logic led,
  output logic irq
);
  localparam int TW = lsc_pkg::TMR_W;

  // ----------------------------------------------------------------
  // One-second time base
  // ----------------------------------------------------------------
  logic [31:0] pre_q;
  logic tick_q;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q <= 32'h0;
      tick_q <= 1'b0;
    end else if (pre_q == 32'(CYC_PER_SEC - 1)) begin
      pre_q <= 32'h0;
      tick_q <= 1'b1;
    end else begin
      pre_q <= pre_q + 32'h1;
      tick_q <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Power source filter
  // ----------------------------------------------------------------
  logic init_q, gen_q, src_done, src_chg, src_to_util;
  // RL14 one-minute stability
  lsc_sec_timer #(.W(TW)) u_src_tmr (
    .clk(pclk),
    .rst_n(presetn),
    .tick(tick_q),
    .load(util_src != gen_q),
    .load_val(lsc_pkg::T_STABLE_S),
    .done(src_done),
    .remain()
  );

  assign src_chg = init_q && (util_src == gen_q) && src_done;
  assign src_to_util = src_chg && gen_q;
  // The source is caught once after reset, since a strap cannot enter the reset value
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      init_q <= 1'b0;
      gen_q <= 1'b0;
    end else if (!init_q) begin
      init_q <= 1'b1;
      gen_q <= !util_src;
    end else if (src_chg) begin
      gen_q <= !gen_q;
    end
  end

  // ----------------------------------------------------------------
  // Test button and software test
  // ----------------------------------------------------------------
  logic btn_q, soft_test_q, test_pulse;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      btn_q <= 1'b0;
    end else begin
      btn_q <= test_btn;
    end
  end

  assign test_pulse = (test_btn && !btn_q) || soft_test_q;

  // ----------------------------------------------------------------
  // Recovery delay from the dial
  // ----------------------------------------------------------------
  logic dial_ok;
  logic [TW-1:0] rec_s;
  assign dial_ok = (dial >= lsc_pkg::DIAL_MIN) && (dial <= lsc_pkg::DIAL_MAX);
  // RL1 base plus step per position
  assign rec_s = dial_ok ? lsc_pkg::T_BASE_S + TW'(lsc_pkg::T_STEP_S * (dial - lsc_pkg::DIAL_MIN))
                         : lsc_pkg::T_BASE_S;

  // ----------------------------------------------------------------
  // Main state machine
  // ----------------------------------------------------------------
  lsc_pkg::lsc_state_e state_q, state_d;
  logic [TW-1:0] tmr_val;
  logic tmr_load, tmr_done, gen_lock, gen_ovl;
  lsc_sec_timer #(.W(TW)) u_state_tmr (
    .clk(pclk),
    .rst_n(presetn),
    .tick(tick_q),
    .load(tmr_load),
    .load_val(tmr_val),
    .done(tmr_done),
    .remain()
  );

  // RL2 lockout only counts on generator
  assign gen_lock = gen_q && lock_sw;
  // RL6 overload sheds only on generator
  assign gen_ovl = gen_q && overload;
  always_comb begin
    state_d = state_q;
    tmr_load = 1'b0;
    tmr_val = rec_s;
    if (!init_q) begin
      state_d = lsc_pkg::ST_SHED;
      tmr_load = 1'b1;
      // RL6 startup window on utility
      tmr_val = util_src ? lsc_pkg::T_BASE_S : rec_s;
    end else if (src_to_util) begin
      // RL15 five minutes from utility return
      state_d = lsc_pkg::ST_SHED;
      tmr_load = 1'b1;
      tmr_val = lsc_pkg::T_BASE_S;
    end else if (gen_lock) begin
      // RL8 generator lockout state
      state_d = lsc_pkg::ST_SWLK;
    end else if (test_pulse) begin
      // RL11 forced shed
      state_d = lsc_pkg::ST_SHED;
      tmr_load = 1'b1;
    end else begin
      unique case (state_q)
        lsc_pkg::ST_NORM: begin
          // RL5 overload sheds
          if (gen_ovl) begin
            state_d = lsc_pkg::ST_SHED;
            tmr_load = 1'b1;
          end
        end
        lsc_pkg::ST_SHED: begin
          if (gen_q && !dial_ok) begin
            // RL16 hold while dial invalid
            tmr_load = 1'b1;
          end else if (tmr_done && gen_q && freq_low) begin
            // RL13 reload the recovery delay plus five minutes
            tmr_load = 1'b1;
            tmr_val = lsc_pkg::T_BASE_S + rec_s;
          end else if (tmr_done) begin
            state_d = lsc_pkg::ST_PROBE;
            tmr_load = 1'b1;
            tmr_val = lsc_pkg::T_PROBE_S;
          end
        end
        lsc_pkg::ST_PROBE: begin
          if (gen_ovl) begin
            // RL7 offending load locked out
            state_d = lsc_pkg::ST_LOCK;
            tmr_load = 1'b1;
            tmr_val = lsc_pkg::T_LOCK_S;
          end else if (tmr_done) begin
            state_d = lsc_pkg::ST_NORM;
          end
        end
        lsc_pkg::ST_LOCK: begin
          if (tmr_done) begin
            state_d = lsc_pkg::ST_PROBE;
            tmr_load = 1'b1;
            tmr_val = lsc_pkg::T_PROBE_S;
          end
        end
        lsc_pkg::ST_SWLK: begin
          // RL4 back to normal recovery once switch released
          state_d = lsc_pkg::ST_SHED;
          tmr_load = 1'b1;
        end
        default: begin
          state_d = lsc_pkg::ST_SHED;
          tmr_load = 1'b1;
        end
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q <= lsc_pkg::ST_NORM;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Contactor drive
  // ----------------------------------------------------------------
  logic cont_d;
  // RL10 closed in normal state
  // RL12 closed until generator overload handling
  // RL16 open on generator with bad dial
  assign cont_d = ((state_d == lsc_pkg::ST_NORM) || (state_d == lsc_pkg::ST_PROBE)) && !(gen_q && !dial_ok);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      contactor <= 1'b1;
    end else begin
      contactor <= cont_d;
    end
  end

  // ----------------------------------------------------------------
  // LED blink codes
  // ----------------------------------------------------------------
  logic [3:0] half_s, blink_q;
  logic phase_q, steady;
  // RL3 RL9 utility shows steady LED via normal state
  assign steady = (state_q == lsc_pkg::ST_NORM) || (state_q == lsc_pkg::ST_PROBE);
  // RL7 RL8 longer blink codes
  assign half_s = (state_q == lsc_pkg::ST_LOCK) ? lsc_pkg::BLINK_LOCK_S :
                  (state_q == lsc_pkg::ST_SWLK) ? lsc_pkg::BLINK_SWLK_S : lsc_pkg::BLINK_SHED_S;
  // Restarting the phase on every state change starts each code with the LED on; the free tick can cut the first blink short
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      blink_q <= 4'h0;
      phase_q <= 1'b1;
    end else if (state_d != state_q) begin
      blink_q <= 4'h0;
      phase_q <= 1'b1;
    end else if (tick_q) begin
      if (blink_q + 4'h1 >= half_s) begin
        blink_q <= 4'h0;
        phase_q <= !phase_q;
      end else begin
        blink_q <= blink_q + 4'h1;
      end
    end
  end
  // RL5 one-second blink in shed
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      led <= 1'b1;
    end else begin
      led <= steady || phase_q;
    end
  end

  // ----------------------------------------------------------------
  // Interrupt events
  // ----------------------------------------------------------------
  logic [lsc_pkg::NUM_EV-1:0] ev, int_stat_q, int_en_q, int_clr;
  always_comb begin
    ev = '0;
    ev[lsc_pkg::EV_SHED] = (state_d == lsc_pkg::ST_SHED) && (state_q != lsc_pkg::ST_SHED);
    ev[lsc_pkg::EV_LOCK] = (state_d == lsc_pkg::ST_LOCK) && (state_q != lsc_pkg::ST_LOCK);
    ev[lsc_pkg::EV_SRC] = src_chg;
    ev[lsc_pkg::EV_CLOSE] = cont_d && !contactor;
  end
  // A new event wins over a clear in the same cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_stat_q <= '0;
    end else begin
      int_stat_q <= (int_stat_q & ~int_clr) | ev;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(((int_stat_q & ~int_clr) | ev) & int_en_q);
    end
  end

  // ----------------------------------------------------------------
  // APB slave
  // ----------------------------------------------------------------
  logic setup, wr_acc, mapped;
  logic [31:0] rd_d, status;
  assign setup = psel && !penable;
  assign wr_acc = psel && penable && pready && pwrite && !pslverr;
  assign mapped = (paddr == lsc_pkg::ADDR_CTRL) || (paddr == lsc_pkg::ADDR_STATUS) ||
                  (paddr == lsc_pkg::ADDR_INT_STAT) || (paddr == lsc_pkg::ADDR_INT_CLR) ||
                  (paddr == lsc_pkg::ADDR_INT_EN);
  assign int_clr = (wr_acc && paddr == lsc_pkg::ADDR_INT_CLR) ? pwdata[lsc_pkg::NUM_EV-1:0] : '0;
  always_comb begin
    status = 32'h0;
    status[lsc_pkg::ST_STATE_LSB +: 5] = state_q;
    status[lsc_pkg::ST_CONT_BIT] = contactor;
    status[lsc_pkg::ST_LED_BIT] = led;
    status[lsc_pkg::ST_GEN_BIT] = gen_q;
    status[lsc_pkg::ST_DIAL_LSB +: 4] = dial;
  end
  always_comb begin
    rd_d = 32'h0;
    unique case (paddr)
      lsc_pkg::ADDR_STATUS: rd_d = status;
      lsc_pkg::ADDR_INT_STAT: rd_d[lsc_pkg::NUM_EV-1:0] = int_stat_q;
      lsc_pkg::ADDR_INT_EN: rd_d[lsc_pkg::NUM_EV-1:0] = int_en_q;
      default: rd_d = 32'h0;
    endcase
  end

  // Fixed one-cycle access phase: ready is raised from the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0;
    end else begin
      pready <= setup;
      pslverr <= setup && !mapped;
      if (setup && !pwrite) begin
        prdata <= rd_d;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      int_en_q <= '0;
    end else if (wr_acc && paddr == lsc_pkg::ADDR_INT_EN) begin
      int_en_q <= pwdata[lsc_pkg::NUM_EV-1:0];
    end
  end

  // Software test is a self-clearing pulse; CTRL reads back zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      soft_test_q <= 1'b0;
    end else begin
      soft_test_q <= wr_acc && (paddr == lsc_pkg::ADDR_CTRL) && pwdata[lsc_pkg::CTRL_TEST_BIT];
    end
  end
endmodule : lsc_ctrl

//--- verif/lsc_ctrl_asserts.sv
// Port-level assertions for the load-shed controller.
// Assumes it is bound to lsc_ctrl and sees only that module's ports.
`timescale 1ns/100ps
module lsc_ctrl_asserts #(
  parameter int CYC_PER_SEC = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [lsc_pkg::APB_AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic [3:0] dial,
  input wire logic lock_sw,
  input wire logic test_btn,
  input wire logic util_src,
  input wire logic overload,
  input wire logic freq_low,
  input wire logic contactor,
  input wire logic led,
  input wire logic irq
);
  // ----
  // Time on generator
  // ----
  // Margin beyond the one-minute source filter, which runs on a free tick
  logic [15:0] gen_q;
  logic gen_ok;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      gen_q <= 16'h0000;
    end else if (util_src) begin
      gen_q <= 16'h0000;
    end else if (gen_q != 16'hffff) begin
      gen_q <= gen_q + 16'h0001;
    end
  end
  assign gen_ok = int'(gen_q) > 62 * CYC_PER_SEC;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ----
  // Properties
  // ----
  a_reset_closed: assert property ($rose(presetn) |-> contactor && led && !irq)
    else $error("contactor or led low after reset");
  a_ready_setup: assert property (psel && !penable |=> pready)
    else $error("no ready after setup");
  a_ready_single: assert property (pready |-> psel && penable ##1 !pready)
    else $error("ready outside one access cycle");
  a_err_unmapped: assert property (psel && !penable && paddr > 8'h10 |=> pslverr)
    else $error("unmapped access not refused");
  a_err_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
    else $error("refused read returned data");
  a_irq_masked: assert property (psel && penable && pready && pwrite && paddr == lsc_pkg::ADDR_INT_EN
    && pwdata[3:0] == 4'h0 |-> ##2 !irq [*2])
    else $error("irq high with all sources masked");
  a_gen_lock_open: assert property (gen_ok && lock_sw && $past(lock_sw) && $past(lock_sw, 2) |-> !contactor)
    else $error("contactor closed with lockout on generator");
  a_bad_dial_open: assert property (gen_ok && (dial == 4'h0 || dial > 4'h8) && $past(dial) == dial
    && $past(dial, 2) == dial |-> !contactor)
    else $error("contactor closed with invalid dial");
  a_ovl_open: assert property (gen_ok && overload |-> ##[1:3] !contactor)
    else $error("overload on generator did not open contactor");
endmodule : lsc_ctrl_asserts

bind lsc_ctrl lsc_ctrl_asserts #(.CYC_PER_SEC(CYC_PER_SEC)) u_asserts (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .dial, .lock_sw, .test_btn, .util_src, .overload, .freq_low, .contactor, .led, .irq
);

//--- verif/lsc_src_model.sv
// Model of the power source and the switched load.
// Assumes the bench picks the source and how heavy the load is.
`timescale 1ns/100ps
module lsc_src_model (
  input wire logic pclk,
  input wire logic on_gen,
  input wire logic heavy,
  input wire logic sag,
  input wire logic contactor,
  output logic util_src = 1'b1,
  output logic overload = 1'b0,
  output logic freq_low = 1'b0
);
  // A heavy load only overloads while it is connected, one cycle late
  always @(posedge pclk) begin
    util_src <= !on_gen;
    overload <= heavy && contactor;
    freq_low <= sag;
  end
endmodule : lsc_src_model

//--- verif/tb_top.sv
// Self-checking bench for the load-shed controller.
// Assumes a shortened one-second tick of CPS clock cycles.
`timescale 1ns/100ps
module tb_top;
  localparam int CPS = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, contactor, led, irq, util_src, overload, freq_low;
  logic [3:0] dial = 4'h3;
  logic lock_sw = 1'b0, test_btn = 1'b0, on_gen = 1'b0, heavy = 1'b0, sag = 1'b0;
  logic [32:0] e;
  logic [32:0] exp_q[$];
  int n_errors = 0, tests_run = 0, seed = 77, cyc = 0, rec;
  always #2.5 pclk = ~pclk;
  always @(posedge pclk) cyc <= cyc + 1;
  lsc_ctrl #(.CYC_PER_SEC(CPS)) dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata, .pready, .pslverr, .dial, .lock_sw, .test_btn, .util_src, .overload, .freq_low,
    .contactor, .led, .irq);
  lsc_src_model u_src (.pclk, .on_gen, .heavy, .sag, .contactor, .util_src, .overload, .freq_low);
  // ----
  // Tasks
  // ----
  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    tests_run++;
    if (seen !== expd) begin
      n_errors++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, expd);
    end
  endtask : check
  task automatic stop_test();
    $display("errors=%0d checks=%0d", n_errors, tests_run);
    if (n_errors == 0 && tests_run > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d, input logic [32:0] x);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    if (!wr) exp_q.push_back(x);
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic load(input logic h);
    @(posedge pclk);
    heavy <= h;
  endtask : load
  task automatic press();
    @(posedge pclk);
    test_btn <= 1'b1;
    @(posedge pclk);
    test_btn <= 1'b0;
  endtask : press
  task automatic opened(output int t0);
    int i;
    for (i = 0; i < 8 && contactor !== 1'b0; i++) @(negedge pclk);
    check({31'h0, contactor}, 32'h0);
    t0 = cyc;
  endtask : opened
  // Free-running tick makes each delay up to a second short
  task automatic span(input int t0, input int s);
    int d;
    while (contactor !== 1'b1) @(negedge pclk);
    d = cyc - t0;
    check((d >= (s - 2) * CPS && d <= s * CPS + 4) ? 32'(s * CPS) : 32'(d), 32'(s * CPS));
  endtask : span
  task automatic blink(input int h);
    int d;
    d = 0;
    while (led !== 1'b0) @(negedge pclk);
    while (led !== 1'b1) @(negedge pclk);
    while (led === 1'b1) begin
      @(negedge pclk);
      d++;
    end
    check(32'(d), 32'(h * CPS));
  endtask : blink
  // ----
  // Read monitor and watchdog
  // ----
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && exp_q.size() > 0) begin
      e = exp_q.pop_front();
      check(prdata, e[31:0]);
      check({31'h0, pslverr}, {31'h0, e[32]});
    end
  end
  initial begin
    repeat (32000) @(posedge pclk);
    n_errors++;
    stop_test();
  end
  // ----
  // Main sequence
  // ----
  initial begin
    int t0, v;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    opened(t0);
    blink(1);
    span(t0, 300);
    @(posedge pclk);
    lock_sw <= 1'b1;
    heavy <= 1'b1;
    repeat (20 * CPS) begin
      @(negedge pclk);
      check({30'h0, contactor, led}, 32'h3);
    end
    @(posedge pclk);
    lock_sw <= 1'b0;
    heavy <= 1'b0;
    apb(1'b1, lsc_pkg::ADDR_INT_EN, 32'hf, 33'h0);
    apb(1'b1, lsc_pkg::ADDR_INT_CLR, 32'hf, 33'h0);
    apb(1'b0, lsc_pkg::ADDR_STATUS, 32'h0, 33'h361);
    apb(1'b0, lsc_pkg::ADDR_INT_STAT, 32'h0, 33'h0);
    apb(1'b0, 8'h20, 32'h0, {1'b1, 32'h0});
    v = 1 + $unsigned($random(seed)) % 8;
    rec = 300 + 15 * (v - 1);
    @(posedge pclk);
    dial <= 4'(v);
    apb(1'b1, lsc_pkg::ADDR_CTRL, 32'h1, 33'h0);
    opened(t0);
    repeat (3) @(negedge pclk);
    check({31'h0, irq}, 32'h1);
    apb(1'b0, lsc_pkg::ADDR_INT_STAT, 32'h0, 33'h1);
    apb(1'b1, lsc_pkg::ADDR_INT_EN, 32'h0, 33'h0);
    repeat (3) @(negedge pclk);
    check({31'h0, irq}, 32'h0);
    span(t0, rec);
    @(posedge pclk);
    on_gen <= 1'b1;
    repeat (62 * CPS) begin
      @(negedge pclk);
      check({31'h0, contactor}, 32'h1);
    end
    load(1'b1);
    opened(t0);
    load(1'b0);
    blink(1);
    span(t0, rec);
    load(1'b1);
    opened(t0);
    load(1'b0);
    blink(3);
    span(t0, 1800);
    press();
    opened(t0);
    @(posedge pclk);
    sag <= 1'b1;
    repeat ((rec + 10) * CPS) @(posedge pclk);
    sag <= 1'b0;
    span(t0, 2 * rec + 300);
    repeat (16 * CPS) @(posedge pclk);
    lock_sw <= 1'b1;
    opened(t0);
    blink(6);
    press();
    repeat (3 * CPS) @(negedge pclk);
    check({31'h0, contactor}, 32'h0);
    @(posedge pclk);
    lock_sw <= 1'b0;
    t0 = cyc;
    span(t0, rec);
    repeat (16 * CPS) @(posedge pclk);
    dial <= 4'h0;
    opened(t0);
    @(posedge pclk);
    dial <= 4'h9;
    repeat (2 * CPS) @(negedge pclk);
    check({31'h0, contactor}, 32'h0);
    @(posedge pclk);
    dial <= 4'(v);
    while (contactor !== 1'b1) @(negedge pclk);
    load(1'b1);
    opened(t0);
    load(1'b0);
    span(t0, rec);
    load(1'b1);
    opened(t0);
    load(1'b0);
    // Utility comes back ten seconds into the thirty-minute lockout
    repeat (10 * CPS) @(posedge pclk);
    on_gen <= 1'b0;
    t0 = cyc;
    span(t0, 360);
    // Shed, lockout, source change and reclose have all been latched since the last clear
    apb(1'b0, lsc_pkg::ADDR_INT_STAT, 32'h0, 33'hf);
    apb(1'b1, lsc_pkg::ADDR_INT_CLR, 32'h5, 33'h0);
    apb(1'b0, lsc_pkg::ADDR_INT_STAT, 32'h0, 33'ha);
    apb(1'b0, lsc_pkg::ADDR_INT_EN, 32'h0, 33'h0);
    // Let the read monitor take the last answer before the queue is checked
    @(posedge pclk);
    check(32'(exp_q.size()), 32'h0);
    stop_test();
  end
endmodule : tb_top
